// *** design/tsp_conv_timer.sv ***
`timescale 1ns/1ps
module tsp_conv_timer
#(
  parameter int CONV_CYCLES = tsp_pkg::TSP_CONV_CYCLES
)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Run permission and converter code.
  input  wire logic        run_en,
  input  wire logic [10:0] temp_code,
  // Status and result.
  output logic             busy,
  output logic             done,
  output logic [10:0]      result
);
  import tsp_pkg::*;

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CONV_CYCLES - 1);

  typedef enum logic {TSP_IDLE, TSP_CONVERT} tsp_conv_state_t;

  typedef struct packed {
    tsp_conv_state_t st;
    logic [CW-1:0]   cnt;
    logic            done;
    logic [10:0]     result;
  } tsp_conv_t;

  tsp_conv_t s;
  tsp_conv_t next_s;

  // Idle restarts at once; losing run_en abandons the conversion.
  always_comb
  begin
    next_s      = s;
    next_s.done = 1'b0;
    unique case (s.st)
      TSP_IDLE:
      begin
        next_s.cnt = '0;
        if (run_en)
          next_s.st = TSP_CONVERT;
      end
      TSP_CONVERT:
      begin
        next_s.cnt = s.cnt + CW'(1);
        if (!run_en)
          next_s.st = TSP_IDLE;
        else if (s.cnt == LAST)
        begin
          next_s.st     = TSP_IDLE;
          next_s.done   = 1'b1;
          next_s.result = temp_code;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s <= '{TSP_IDLE, '0, 1'b0, TSP_TEMP_RESET};
    else
      s <= next_s;
  end

  assign busy   = (s.st == TSP_CONVERT);
  assign done   = s.done;
  assign result = s.result;
endmodule // tsp_conv_timer

// *** design/tsp_link_if.sv ***
`timescale 1ns/1ps
// Synchronised link levels and one-cycle edge events.
interface tsp_link_if;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sc_rise;
  logic sc_fall;
  logic sio_data;
  modport sync (output cs_low, cs_fall, cs_rise, sc_rise, sc_fall, sio_data);
  modport core (input cs_low, cs_fall, cs_rise, sc_rise, sc_fall, sio_data);
endinterface

// *** design/tsp_link_sync.sv ***
`timescale 1ns/1ps
module tsp_link_sync
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Raw pins: chip select, serial clock, data.
  input wire logic cs_n_pin,
  input wire logic sc_pin,
  input wire logic sio_pin,
  // Synchronised view.
  tsp_link_if.sync lnk
);
  import tsp_pkg::*;

  // Bits are {cs_n, sc, sio}; meta is read only by stab.
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] stab;
    logic [2:0] prev;
  } tsp_sync_t;

  tsp_sync_t s;
  tsp_sync_t next_s;

  // Two flops per pin, a third to find edges.
  always_comb
  begin
    next_s      = s;
    next_s.meta = {cs_n_pin, sc_pin, sio_pin};
    next_s.stab = s.meta;
    next_s.prev = s.stab;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s <= '{TSP_PIN_RESET, TSP_PIN_RESET, TSP_PIN_RESET};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign lnk.cs_low   = ~s.stab[2];
  assign lnk.cs_fall  = s.prev[2] & ~s.stab[2];
  assign lnk.cs_rise  = ~s.prev[2] & s.stab[2];
  assign lnk.sc_rise  = ~s.prev[1] & s.stab[1];
  assign lnk.sc_fall  = s.prev[1] & ~s.stab[1];
  assign lnk.sio_data = s.stab[0];
endmodule // tsp_link_sync

// *** design/tsp_pkg.sv ***
package tsp_pkg;
  // Word and field widths of the serial exchange.
  localparam int TSP_WORD_W = 16;
  localparam int TSP_TEMP_W = 11;
  localparam int TSP_CMD_W  = 8;
  // Clock counts inside one 32-clock exchange.
  localparam logic [4:0] TSP_TX_BITS  = 5'h0e;
  localparam logic [4:0] TSP_RX_START = 5'h10;
  localparam logic [4:0] TSP_LAST_CLK = 5'h1f;
  localparam logic [4:0] TSP_CNT_ZERO = 5'h00;
  // Command byte that selects shutdown.
  localparam logic [7:0] TSP_CMD_SHUTDOWN = 8'hff;
  // Fixed low fields of the two output words.
  localparam logic [2:0] TSP_TEMP_FILL = 3'h7;
  localparam logic [2:0] TSP_ID_FILL   = 3'h0;
  localparam logic [1:0] TSP_UNDRIVEN  = 2'h0;
  // Values after reset.
  localparam logic [10:0] TSP_TEMP_RESET     = 11'h000;
  localparam logic [7:0]  TSP_CMD_RESET      = 8'h00;
  localparam logic        TSP_SHUTDOWN_RESET = 1'b0;
  localparam logic [2:0]  TSP_PIN_RESET      = 3'h4;
  // Conversion period, in its own unit and in clock cycles.
  localparam int TSP_CLK_PERIOD_NS = 5;
  localparam int TSP_CONV_TIME_MS  = 210;
  localparam int TSP_CONV_CYCLES   =
    TSP_CONV_TIME_MS * 1000000 / TSP_CLK_PERIOD_NS;
  // Identification code; the value is arbitrary.
  localparam logic [10:0] TSP_ID_CODE_DEFAULT = 11'h2a5;

  // Builds the word that the transmit phase shifts out.
  function automatic logic [15:0] tsp_tx_word(
    input logic        shut,
    input logic [10:0] temp,
    input logic [10:0] id_code);
    if (shut)
      return {id_code, TSP_ID_FILL, TSP_UNDRIVEN};
    return {temp, TSP_TEMP_FILL, TSP_UNDRIVEN};
  endfunction
endpackage

// *** design/tsp_sensor_port.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - reset gives continuous conversion, not shutdown.
// - output invalid until first conversion completes.
// - drive on falling, sample on rising.
// - 32 clocks: 16 transmit, 16 receive.
// - data pin released while select high.
// - first bit driven at select fall.
// - release pin after fourteen bits.
// - select may rise early, no error.
// - new result loads only after select high.
// - decode last eight bits received.
// - all ones shuts down, any zero wakes.
// - temperature in bits 15..5, quarter degree.
// - bits 4..2 ones, bits 1..0 undriven.
// - most significant bit goes first.
// - shutdown returns identification word, port alive.
// - identification code, zeros, undriven low bits.
// - mode command low byte only, write-only.
// - three registers, no other readback path.
// - read any time, refresh, restart conversion (here a read never restarts it; conversion runs on regardless).
module tsp_sensor_port
#(
  parameter int          CONV_CYCLES = tsp_pkg::TSP_CONV_CYCLES,
  parameter logic [10:0] ID_CODE     = tsp_pkg::TSP_ID_CODE_DEFAULT
)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Serial link pins.
  input  wire logic        cs_n_pin,
  input  wire logic        serial_clock_in,
  input  wire logic        sio_in,
  output logic             sio_out,
  output logic             sio_oe,
  // Converter code, same clock domain.
  input  wire logic [10:0] temp_code,
  // Status.
  output logic             shutdown,
  output logic             conv_valid,
  output logic             conv_busy
);
  import tsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link synchroniser and conversion timer.

  tsp_link_if lnk ();

  // Every pin passes two flops before the core reads it.
  tsp_link_sync u_sync
  (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .cs_n_pin (cs_n_pin),
    .sc_pin   (serial_clock_in),
    .sio_pin  (sio_in),
    .lnk      (lnk)
  );

  logic        conv_done;   // One-cycle completion pulse.
  logic [10:0] conv_result; // Code captured at completion.
  logic        run_en;      // Converter may run.

  // Conversions run only outside shutdown.
  assign run_en = ~shutdown;

  tsp_conv_timer #(.CONV_CYCLES(CONV_CYCLES)) u_conv
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .run_en    (run_en),
    .temp_code (temp_code),
    .busy      (conv_busy),
    .done      (conv_done),
    .result    (conv_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State of the port.

  // Only the result, the code word and the mode are held; the mode
  // can be written but never read back, and nothing else is exposed.
  typedef struct packed {
    logic [15:0] shift;      // Output shift register.
    logic [4:0]  fall_cnt;   // Falling edges in this exchange.
    logic [4:0]  rise_cnt;   // Rising edges in this exchange.
    logic [7:0]  cmd;        // Input shift register.
    logic        rx_seen;    // Receive bits since last decode.
    logic        shutdown;   // Mode control, decoded.
    logic [10:0] temp_q;     // Temperature result register.
    logic [10:0] pend;       // Result waiting for select high.
    logic        pend_valid; // A result is waiting.
    logic        conv_valid; // First conversion has finished.
  } tsp_port_t;

  tsp_port_t s;
  tsp_port_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Edges count only while select is low, so stray clocks outside
  // an exchange do nothing. A falling edge counts only after a
  // rising one, which keeps a clock that idles high from shifting
  // the first bit away before the master has sampled it.
  always_comb
  begin
    next_s = s;

    // A finished conversion is parked; it never disturbs a word
    // already being shifted out.
    if (conv_done)
    begin
      next_s.pend       = conv_result;
      next_s.pend_valid = 1'b1;
      next_s.conv_valid = 1'b1;
    end

    // The result register refreshes only while select is high.
    if (!lnk.cs_low && next_s.pend_valid)
    begin
      next_s.temp_q     = next_s.pend;
      next_s.pend_valid = 1'b0;
    end

    if (lnk.cs_fall)
    begin
      // New exchange: load the word, start aligned.
      next_s.shift    = tsp_tx_word(s.shutdown, s.temp_q, ID_CODE);
      next_s.fall_cnt = TSP_CNT_ZERO;
      next_s.rise_cnt = TSP_CNT_ZERO;
      next_s.cmd      = TSP_CMD_RESET;
      next_s.rx_seen  = 1'b0;
    end
    else if (lnk.cs_low && lnk.sc_rise)
    begin
      // Input sampled on rising edges in clocks 17 to 32.
      if (s.rise_cnt >= TSP_RX_START)
      begin
        next_s.cmd     = {s.cmd[6:0], lnk.sio_data};
        next_s.rx_seen = 1'b1;
      end
      // Clock 32 closes the exchange; decode so that the next
      // transmit phase already reflects the new mode.
      if (s.rise_cnt == TSP_LAST_CLK)
      begin
        next_s.shutdown = (next_s.cmd == TSP_CMD_SHUTDOWN);
        next_s.rx_seen  = 1'b0;
      end
      next_s.rise_cnt = s.rise_cnt + 5'h01;
    end
    else if (lnk.cs_low && lnk.sc_fall && (s.rise_cnt != s.fall_cnt))
    begin
      next_s.fall_cnt = s.fall_cnt + 5'h01;
      // Wrap after 32 clocks starts the next transmit phase.
      if (next_s.fall_cnt == TSP_CNT_ZERO)
        next_s.shift = tsp_tx_word(s.shutdown, s.temp_q, ID_CODE);
      else
        next_s.shift = {s.shift[14:0], 1'b0};
    end
    else if (lnk.cs_rise && s.rx_seen)
    begin
      // Early end: the last eight bits taken decide the mode. A
      // select rise in the transmit phase has nothing to decode and
      // simply leaves the port idle, so truncation is harmless.
      next_s.shutdown = (s.cmd == TSP_CMD_SHUTDOWN);
      next_s.rx_seen  = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Reset puts the port in continuous conversion with a cleared
  // result, so the first word out holds no real temperature.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s.shift      <= '0;
      s.fall_cnt   <= TSP_CNT_ZERO;
      s.rise_cnt   <= TSP_CNT_ZERO;
      s.cmd        <= TSP_CMD_RESET;
      s.rx_seen    <= 1'b0;
      s.shutdown   <= TSP_SHUTDOWN_RESET;
      s.temp_q     <= TSP_TEMP_RESET;
      s.pend       <= TSP_TEMP_RESET;
      s.pend_valid <= 1'b0;
      s.conv_valid <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Data from the shift register; the enable covers the first
  // fourteen bit slots of each transmit phase only. The cs_fall
  // term hides the stale count for the one cycle before reload.
  assign sio_out    = s.shift[15];
  assign sio_oe     = lnk.cs_low & ~lnk.cs_fall
                    & (s.fall_cnt < TSP_TX_BITS);
  assign shutdown   = s.shutdown;
  assign conv_valid = s.conv_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Start of an exchange, seen one cycle later.
  sequence s_start;
    lnk.cs_fall ##1 1'b1;
  endsequence

  // Thirty-second rising edge with the command complete.
  sequence s_shut_cmd;
    lnk.cs_low && lnk.sc_rise && !lnk.cs_fall
      && (s.rise_cnt == TSP_LAST_CLK)
      && ({s.cmd[6:0], lnk.sio_data} == TSP_CMD_SHUTDOWN);
  endsequence

  a_pin_released: assert property (!lnk.cs_low |-> !sio_oe)
    else $error("Data pin driven while select high.");

  a_first_bit_load: assert property (
    lnk.cs_fall |=> (s.shift == tsp_tx_word($past(s.shutdown), $past(s.temp_q),
      ID_CODE)) && sio_oe)
    else $error("First bit not presented after select fall.");

  a_align_on_select: assert property (
    s_start |-> (s.cmd == TSP_CMD_RESET) && (s.rise_cnt == TSP_CNT_ZERO)
      && (s.fall_cnt == TSP_CNT_ZERO))
    else $error("Exchange did not start aligned.");

  a_release_after_14: assert property (
    (s.fall_cnt >= TSP_TX_BITS) |-> !sio_oe)
    else $error("Data pin driven past fourteen bits.");

  a_shutdown_entry: assert property (s_shut_cmd |=> shutdown)
    else $error("All-ones command did not enter shutdown.");

  a_result_frozen: assert property (
    (lnk.cs_low && $past(lnk.cs_low)) |-> $stable(s.temp_q))
    else $error("Result register changed during an exchange.");

  a_id_in_shutdown: assert property (
    (lnk.cs_fall && shutdown) |=> (s.shift[15:5] == ID_CODE)
      && (s.shift[4:2] == TSP_ID_FILL))
    else $error("Shutdown exchange did not load the code word.");

  a_msb_first: assert property (
    (lnk.cs_low && lnk.sc_fall && !lnk.cs_fall && (s.rise_cnt != s.fall_cnt)
      && (s.fall_cnt < TSP_TX_BITS))
      |=> (s.shift == {$past(s.shift[14:0]), 1'b0}))
    else $error("Output word not shifted toward the top bit.");

  a_conv_suspend: assert property (shutdown |=> !conv_busy)
    else $error("Conversion kept running in shutdown.");

  a_refresh_idle: assert property (
    (conv_done && !lnk.cs_low) |=> (s.temp_q == $past(conv_result)))
    else $error("Idle result register not refreshed.");

  a_valid_first: assert property (
    (!conv_valid && !conv_done) |=> !conv_valid)
    else $error("Valid flag rose without a conversion.");

  // Thirty-second rising edge with a command that holds a zero.
  sequence s_wake_cmd;
    lnk.cs_low && lnk.sc_rise && !lnk.cs_fall
      && (s.rise_cnt == TSP_LAST_CLK)
      && ({s.cmd[6:0], lnk.sio_data} != TSP_CMD_SHUTDOWN);
  endsequence

  // Any zero in the captured byte must leave shutdown.
  a_wake_on_zero: assert property (s_wake_cmd |=> !shutdown)
    else $error("Command with a zero did not wake the port.");

  // A temperature word carries the result on top and three ones below.
  a_temp_fill: assert property (
    (lnk.cs_fall && !shutdown) |=> (s.shift[15:5] == $past(s.temp_q))
      && (s.shift[4:2] == TSP_TEMP_FILL))
    else $error("Temperature word not formed as expected.");

  // In the receive phase each rising edge shifts the line into the byte.
  a_rx_capture: assert property (
    (lnk.cs_low && lnk.sc_rise && !lnk.cs_fall && (s.rise_cnt >= TSP_RX_START))
      |=> (s.cmd == {$past(s.cmd[6:0]), $past(lnk.sio_data)}))
    else $error("Receive bit not shifted into the command byte.");

  // A select rise after receive bits decodes the byte held then.
  a_early_decode: assert property (
    (lnk.cs_rise && s.rx_seen)
      |=> (shutdown == ($past(s.cmd) == TSP_CMD_SHUTDOWN)))
    else $error("Early select rise did not decode the command.");

  // With select high no clock edge may move the bit counters; this
  // is what keeps a free-running clock from upsetting the next frame.
  a_idle_no_count: assert property (
    !lnk.cs_low |=> $stable(s.rise_cnt) && $stable(s.fall_cnt))
    else $error("Bit counters moved while select was high.");

endmodule // tsp_sensor_port

// *** tb/temp_sensor_serial_port_tb.sv ***
`timescale 1ns/1ps
module temp_sensor_serial_port_tb;
  import tsp_pkg::*;
  // Short conversion keeps the run brief; the identity value is arbitrary.
  localparam int          CONV   = 200;
  localparam logic [10:0] ID_VAL = 11'h53a;
  logic        clk;
  logic        sys_rst;
  logic        cs_n;
  logic        sc;
  logic        mst_oe;
  logic        mst_d;
  logic        lvl;
  logic        flt;
  logic        sio_out;
  logic        sio_oe;
  logic        shutdown;
  logic        conv_valid;
  logic        conv_busy;
  logic [10:0] temp_code;
  int          error_cnt;
  int          comparisons;
  logic [15:0] tab [4] = '{16'h4b1f, 16'he49f, 16'hffff, 16'h003f};
  logic [15:0] id_w;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a released line that flips every cycle so no stale level hides.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial flt = 1'b0;
  always @(posedge clk) flt <= ~flt;
  assign lvl = sio_oe ? sio_out : (mst_oe ? mst_d : flt);
  assign id_w = {ID_VAL, TSP_ID_FILL, 2'h0};

  tsp_sensor_port #(.CONV_CYCLES(CONV), .ID_CODE(ID_VAL)) u_dut
  (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .cs_n_pin        (cs_n),
    .serial_clock_in (sc),
    .sio_in          (lvl),
    .sio_out         (sio_out),
    .sio_oe          (sio_oe),
    .temp_code       (temp_code),
    .shutdown        (shutdown),
    .conv_valid      (conv_valid),
    .conv_busy       (conv_busy)
  );

  tsp_master_model u_mst
  (
    .clk      (clk),
    .cs_n     (cs_n),
    .sc       (sc),
    .mst_oe   (mst_oe),
    .mst_d    (mst_d),
    .wire_lvl (lvl),
    .dev_oe   (sio_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Comparison helpers; case inequality so an unknown never matches.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Checks one 16-clock transmit slot: 14 driven bits, then two released.
  task automatic chk_word(input int f, input logic [15:0] w);
    chk(u_mst.rx_oe[63 - 16 * f -: 16], 16'hfffc, "drive mask");
    chk(u_mst.rx_bits[63 - 16 * f -: 16] & 16'hfffc, w & 16'hfffc, "word");
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    error_cnt   = 0;
    comparisons = 0;
    sys_rst     = 1'b1;
    temp_code   = 11'h064;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(shutdown, 1'b0, "mode after reset");
    chk(sio_oe, 1'b0, "idle line");
    // Conversion ends mid-frame, so the reset result is still sent.
    u_mst.xfer(16, '0);
    chk_word(0, {TSP_TEMP_RESET, TSP_TEMP_FILL, 2'h0});
    chk(conv_valid, 1'b1, "first result");
    // Temperature codes from the transfer table, fill bits high.
    foreach (tab[i])
    begin
      temp_code <= tab[i][15:5];
      repeat (2 * CONV + 10) @(posedge clk);
      u_mst.xfer(16, '0);
      chk_word(0, tab[i]);
    end
    // A truncated read must leave the next frame aligned.
    u_mst.xfer(5, '0);
    chk(u_mst.rx_bits[63:59], tab[3][15:11], "short read");
    u_mst.xfer(16, '0);
    chk_word(0, tab[3]);
    // Identification read with select held low throughout.
    u_mst.xfer(56, {16'h0, 16'hffff, 16'h0, 8'h03, 8'h00});
    chk_word(0, tab[3]);
    chk_word(2, id_w);
    chk(shutdown, 1'b0, "woken");
    // Only the last eight received bits count; the upper byte is ignored.
    u_mst.xfer(32, {16'h0, 16'h00ff, 32'h0});
    chk(shutdown, 1'b1, "shut");
    repeat (CONV) @(posedge clk);
    chk(conv_busy, 1'b0, "halted");
    u_mst.xfer(16, '0);
    chk_word(0, id_w);
    // Each code with fewer than eight trailing ones wakes the device; all ones shuts it again.
    for (int i = 0; i < 8; i++)
    begin
      u_mst.xfer(32, {16'h0, 8'hff, 8'((16'h1 << i) - 16'h1), 32'h0});
      chk(shutdown, 1'b0, "code wakes");
      u_mst.xfer(32, {16'h0, 16'hffff, 32'h0});
      chk(shutdown, 1'b1, "code shuts");
    end
    u_mst.xfer(32, {16'h0, 16'h0000, 32'h0});
    chk(shutdown, 1'b0, "final wake");
    // Right after waking the old result is still presented.
    temp_code <= tab[0][15:5];
    u_mst.xfer(16, '0);
    chk_word(0, tab[3]);
    repeat (2 * CONV + 10) @(posedge clk);
    u_mst.xfer(16, '0);
    chk_word(0, tab[0]);
    chk(sio_oe, 1'b0, "released");
    print_verdict();
  end

  // Watchdog: the sequence needs about 29500 cycles.
  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule // temp_sensor_serial_port_tb

// *** tb/tsp_master_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Serial bus master: drives select, clock and data, samples the shared line.
module tsp_master_model
(
  // Clock.
  input  wire logic clk,
  // Link pins driven by the master.
  output logic      cs_n,
  output logic      sc,
  output logic      mst_oe,
  output logic      mst_d,
  // Resolved line level and device drive enable.
  input  wire logic wire_lvl,
  input  wire logic dev_oe
);
  // Bit seen at each rising edge, and whether the device drove it.
  logic [63:0] rx_bits;
  logic [63:0] rx_oe;

  // The clock rests low between frames so no stray edge reaches the device.
  initial
  begin
    cs_n   = 1'b1;
    sc     = 1'b0;
    mst_oe = 1'b0;
    mst_d  = 1'b0;
  end

  // One frame of n serial clocks; tx holds the bits sent in receive phases.
  task automatic xfer(input int n, input logic [63:0] tx);
    rx_bits = '0;
    rx_oe   = '0;
    @(posedge clk);
    cs_n <= 1'b0;
    // Setup from select low to the first rising edge exceeds 100 ns.
    repeat (20) @(posedge clk);
    for (int k = 0; k < n; k++)
    begin
      sc     <= 1'b0;
      mst_oe <= (k % 32) >= 16;
      mst_d  <= tx[63 - k];
      repeat (16) @(posedge clk);
      rx_bits[63 - k] = wire_lvl;
      rx_oe[63 - k]   = dev_oe;
      sc <= 1'b1;
      repeat (16) @(posedge clk);
    end
    sc <= 1'b0;
    repeat (16) @(posedge clk);
    cs_n   <= 1'b1;
    mst_oe <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
endmodule // tsp_master_model
